// ===== magnet_pkg.sv
// Purpose: Shared constants and types for the magnet response controller
// Assumes: 200 MHz ref_clk, 10 ms slow tick derived from it
// Notes:   Register byte offsets are word aligned on a 32-bit APB bus
package magnet_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int unsigned CLK_PERIOD_NS   = 5;
	localparam int unsigned TICK_PERIOD_NS  = 10_000_000;
	localparam int unsigned TICK_CYCLES     = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int unsigned TICK_MS         = TICK_PERIOD_NS / 1_000_000;
	localparam int unsigned MODE_HOLD_MS    = 30_000;
	localparam int unsigned REARM_MS        = 2_000;
	localparam int unsigned RESTORE_MS      = 2_000;
	localparam int unsigned ABORT_MS        = 1_000;
	localparam int unsigned DIVERT_MS       = 2_000;
	localparam int unsigned CNT_W           = 12;
	localparam logic [CNT_W-1:0] MODE_HOLD_TICKS = CNT_W'(MODE_HOLD_MS / TICK_MS);
	localparam logic [CNT_W-1:0] REARM_TICKS     = CNT_W'(REARM_MS / TICK_MS);
	localparam logic [CNT_W-1:0] RESTORE_TICKS   = CNT_W'(RESTORE_MS / TICK_MS);
	localparam logic [CNT_W-1:0] ABORT_TICKS     = CNT_W'(ABORT_MS / TICK_MS);
	// Strictly more than the divert time
	localparam logic [CNT_W-1:0] DIVERT_TICKS    = CNT_W'(DIVERT_MS / TICK_MS + 1);

	////////////////////////////////////////////////////////////////////////////////
	// Register map
	localparam logic [11:0] CTRL_OFFSET       = 12'h000;
	localparam logic [11:0] MODE_OFFSET       = 12'h004;
	localparam logic [11:0] STATE_OFFSET      = 12'h008;
	localparam logic [11:0] IRQ_STATUS_OFFSET = 12'h00C;
	localparam logic [11:0] IRQ_CLEAR_OFFSET  = 12'h010;
	localparam logic [11:0] IRQ_ENABLE_OFFSET = 12'h014;

	localparam int unsigned CTRL_MAGNET_EN_BIT  = 0;
	localparam int unsigned CTRL_MODE_CHG_BIT   = 1;
	localparam int unsigned STATE_PRESENT_BIT   = 0;
	localparam int unsigned STATE_TEMP_MON_BIT  = 1;
	localparam int unsigned STATE_INHIBIT_BIT   = 2;
	localparam int unsigned STATE_EFF_MODE_LSB  = 4;

	localparam int unsigned EV_ARRIVE   = 0;
	localparam int unsigned EV_REMOVE   = 1;
	localparam int unsigned EV_MODE_CHG = 2;
	localparam int unsigned EV_WITHHELD = 3;
	localparam int unsigned EV_DUMP     = 4;
	localparam int unsigned EV_W        = 5;

	localparam logic [1:0]      CTRL_RESET = 2'h0;
	localparam logic [EV_W-1:0] IRQ_RESET  = 5'h00;

	////////////////////////////////////////////////////////////////////////////////
	// Types
	typedef enum logic [1:0] {
		MODE_STORAGE      = 2'b00,
		MODE_OFF          = 2'b01,
		MODE_MONITOR_ONLY = 2'b10,
		MODE_MON_THERAPY  = 2'b11
	} tachy_mode_type;

	localparam tachy_mode_type MODE_RESET = MODE_STORAGE;

	typedef struct packed {
		logic inhibit;
		logic charge_abort;
		logic dump_to_load;
		logic shock_divert;
		logic train_stop;
	} therapy_ctrl_type;

endpackage : magnet_pkg

// ===== level_hold_timer.sv
// Purpose: Synchronise a level and count slow ticks since its last change
// Assumes: tick_en is a one-cycle pulse, clk_en gates all state
// Notes:   Count saturates so long holds never wrap
`timescale 1ns/100ps
module level_hold_timer
	import magnet_pkg::*;
(
	input  wire logic             ref_clk,
	input  wire logic             reset_n,
	input  wire logic             clk_en,
	input  wire logic             tick_en,
	input  wire logic             level_in,
	output logic                  level_out,
	output logic [CNT_W-1:0]      held_ticks
);
	logic meta_r;
	logic sync_r;
	logic last_r;

	// First stage feeds only the second stage
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
		end else if (clk_en) begin
			meta_r <= level_in;
			sync_r <= meta_r;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			last_r     <= 1'b0;
			held_ticks <= '0;
		end else if (clk_en) begin
			last_r <= sync_r;
			if (sync_r != last_r) begin
				held_ticks <= '0; // see R14
			end else if (tick_en && held_ticks != '1) begin
				held_ticks <= held_ticks + CNT_W'(1);
			end
		end
	end

	assign level_out = last_r;

endmodule : level_hold_timer

// ===== magnet_response_controller.sv
// Purpose: Reed switch magnet handling: tones, mode change, therapy inhibit
// Assumes: Therapy status inputs synchronous to ref_clk; APB zero-wait slave
// Notes:   Bradycardia pacing has no path through this block at all
//
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/100ps

// Notes on behaviour
// R1 - With magnet functions disabled the reed switch causes no tone, mode change or inhibit.
// R2 - A held magnet gives beat-synchronous tones in monitor-plus-therapy, else a steady tone.
// R3 - A mode change needs both enables and a 30 s continuous hold.
// R4 - A hold maps therapy to off, off to therapy, monitor-only to therapy, storage unchanged.
// R5 - The tone pattern follows the new mode as soon as the change takes effect.
// R6 - The magnet must be away two seconds and reapplied before another change is allowed.
// R7 - A present magnet blocks any therapy or induction start while detection keeps running.
// R8 - Therapy or off acts as monitor-only under the magnet until two seconds after removal.
// R9 - Charging under the magnet is ended within one to two seconds and dumped to the load.
// R10 - A charged capacitor is diverted after a hold of more than 2 s; no shock with magnet.
// R11 - Burst or induction pulses stop 1 to 2 s after arrival and none restart under magnet.
// R12 - Bradycardia pacing never depends on magnet state.
// R13 - Detection during temporary monitor-only is logged as therapy withheld.
// R14 - The reed input is synchronised and durations are timed on a slow tick, restarting on change.
module magnet_response_controller
	import magnet_pkg::*;
#(
	parameter int unsigned TICK_DIV = TICK_CYCLES
)(
	input  wire logic             ref_clk,
	input  wire logic             reset_n,
	input  wire logic             clk_en,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [11:0]      paddr,
	input  wire logic [31:0]      pwdata,
	output logic [31:0]           prdata,
	output logic                  pready,
	output logic                  pslverr,
	input  wire logic             reed_in,
	input  wire logic             vsense_in,
	input  wire logic             detection_met_in,
	input  wire logic             charging_in,
	input  wire logic             charge_done_in,
	input  wire logic             burst_pacing_therapy_in,
	input  wire logic             induction_in,
	output tachy_mode_type        effective_mode,
	output logic                  tone_steady,
	output logic                  tone_beat,
	output therapy_ctrl_type      therapy_ctrl,
	output logic                  withheld_log,
	output logic                  irq
);

	////////////////////////////////////////////////////////////////////////////////
	// Slow tick
	logic [31:0] tick_cnt_r;
	logic        tick_r;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			tick_cnt_r <= '0;
			tick_r     <= 1'b0;
		end else if (clk_en) begin
			tick_r <= (tick_cnt_r == 32'(TICK_DIV - 1));
			if (tick_cnt_r == 32'(TICK_DIV - 1)) begin
				tick_cnt_r <= '0;
			end else begin
				tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Reed switch timing
	logic             reed_level;
	logic [CNT_W-1:0] held_ticks;
	logic             reed_prev_r;

	level_hold_timer u_reed_timer (
		.ref_clk    (ref_clk),
		.reset_n    (reset_n),
		.clk_en     (clk_en),
		.tick_en    (tick_r),
		.level_in   (reed_in),
		.level_out  (reed_level),
		.held_ticks (held_ticks)
	); // see R14

	////////////////////////////////////////////////////////////////////////////////
	// Control registers
	logic [1:0]      ctrl_r;
	tachy_mode_type  mode_r;
	tachy_mode_type  mode_nxt;
	logic [EV_W-1:0] irq_status_r;
	logic [EV_W-1:0] irq_enable_r;
	logic [EV_W-1:0] events;
	logic            magnet_en;
	logic            present;
	logic            arrive;
	logic            remove;
	logic            mode_change;
	logic            change_done_r;
	logic            temp_mon_r;
	logic            dump_r;
	logic            wr_access;
	logic            setup;

	assign magnet_en = ctrl_r[CTRL_MAGNET_EN_BIT];
	assign present   = magnet_en && reed_level; // see R1
	assign arrive    = present && !reed_prev_r;
	assign remove    = magnet_en && !reed_level && reed_prev_r;
	assign setup     = psel && !penable;
	assign wr_access = psel && penable && pwrite;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			reed_prev_r <= 1'b0;
		end else if (clk_en) begin
			reed_prev_r <= reed_level;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Magnet mode change
	assign mode_change = present && ctrl_r[CTRL_MODE_CHG_BIT] && !change_done_r
		&& held_ticks >= MODE_HOLD_TICKS && mode_r != MODE_STORAGE; // see R3

	always_comb begin
		case (mode_r)
			MODE_MON_THERAPY:  mode_nxt = MODE_OFF;         // see R4
			MODE_OFF:          mode_nxt = MODE_MON_THERAPY; // see R4
			MODE_MONITOR_ONLY: mode_nxt = MODE_MON_THERAPY; // see R4
			MODE_STORAGE:      mode_nxt = MODE_STORAGE;     // see R4
			default:           mode_nxt = mode_r;
		endcase
	end

	// One change per hold; rearmed only after a long enough absence
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			change_done_r <= 1'b0;
		end else if (clk_en) begin
			if (mode_change) begin
				change_done_r <= 1'b1;
			end else if (!reed_level && held_ticks >= REARM_TICKS) begin
				change_done_r <= 1'b0; // see R6
			end
		end
	end

	// Hardware change wins over a software write in the same cycle
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			mode_r <= MODE_RESET;
		end else if (clk_en) begin
			if (mode_change) begin
				mode_r <= mode_nxt;
			end else if (wr_access && paddr == MODE_OFFSET) begin
				mode_r <= tachy_mode_type'(pwdata[1:0]);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Temporary monitor-only
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			temp_mon_r <= 1'b0;
		end else if (clk_en) begin
			if (!magnet_en) begin
				temp_mon_r <= 1'b0;
			end else if (arrive && (mode_r == MODE_MON_THERAPY || mode_r == MODE_OFF)) begin
				temp_mon_r <= 1'b1; // see R8
			end else if (!reed_level && held_ticks >= RESTORE_TICKS) begin
				temp_mon_r <= 1'b0; // see R8
			end
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			effective_mode <= MODE_RESET;
		end else if (clk_en) begin
			effective_mode <= temp_mon_r ? MODE_MONITOR_ONLY : mode_r; // see R8
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Tones: pattern follows the stored mode, so it switches with it
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			tone_steady <= 1'b0;
			tone_beat   <= 1'b0;
		end else if (clk_en) begin
			tone_steady <= present && mode_r != MODE_MON_THERAPY; // see R2, R5
			tone_beat   <= present && mode_r == MODE_MON_THERAPY && vsense_in; // see R2
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Therapy and induction inhibit
	// The short grace on charge and trains tolerates a magnet swept past the can
	// Pacing has no port on this block, so magnet state cannot alter it; see R12
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			therapy_ctrl <= '0;
			dump_r       <= 1'b0;
		end else if (clk_en) begin
			therapy_ctrl.inhibit      <= present; // see R7
			therapy_ctrl.charge_abort <= present && charging_in
				&& held_ticks >= ABORT_TICKS; // see R9
			dump_r <= present && (charging_in || charge_done_in)
				&& held_ticks >= ABORT_TICKS;
			therapy_ctrl.dump_to_load <= dump_r; // see R9
			therapy_ctrl.shock_divert <= present && charge_done_in
				&& held_ticks >= DIVERT_TICKS; // see R10
			therapy_ctrl.train_stop   <= present
				&& (held_ticks >= ABORT_TICKS
				|| !(burst_pacing_therapy_in || induction_in)); // see R11
		end
	end

	// Detection itself is never gated here
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			withheld_log <= 1'b0;
		end else if (clk_en) begin
			withheld_log <= detection_met_in && temp_mon_r; // see R13
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Interrupts
	assign events[EV_ARRIVE]   = arrive;
	assign events[EV_REMOVE]   = remove;
	assign events[EV_MODE_CHG] = mode_change;
	assign events[EV_WITHHELD] = detection_met_in && temp_mon_r;
	assign events[EV_DUMP]     = dump_r && !therapy_ctrl.dump_to_load;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_status_r <= IRQ_RESET;
		end else if (clk_en) begin
			if (wr_access && paddr == IRQ_CLEAR_OFFSET) begin
				irq_status_r <= (irq_status_r & ~pwdata[EV_W-1:0]) | events;
			end else begin
				irq_status_r <= irq_status_r | events;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			irq <= 1'b0;
		end else if (clk_en) begin
			irq <= |(irq_status_r & irq_enable_r);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// APB slave: data decided in setup so access completes with no wait
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_r       <= CTRL_RESET;
			irq_enable_r <= IRQ_RESET;
		end else if (clk_en && wr_access) begin
			if (paddr == CTRL_OFFSET) begin
				ctrl_r <= pwdata[1:0];
			end
			if (paddr == IRQ_ENABLE_OFFSET) begin
				irq_enable_r <= pwdata[EV_W-1:0];
			end
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else if (clk_en) begin
			pready <= 1'b1;
			if (setup) begin
				pslverr <= 1'b0;
				prdata  <= 32'h0000_0000;
				case (paddr)
					CTRL_OFFSET:       prdata[1:0] <= ctrl_r;
					MODE_OFFSET:       prdata[1:0] <= mode_r;
					STATE_OFFSET: begin
						prdata[STATE_PRESENT_BIT]  <= reed_level;
						prdata[STATE_TEMP_MON_BIT] <= temp_mon_r;
						prdata[STATE_INHIBIT_BIT]  <= present;
						prdata[STATE_EFF_MODE_LSB +: 2] <= effective_mode;
					end
					IRQ_STATUS_OFFSET: prdata[EV_W-1:0] <= irq_status_r;
					IRQ_CLEAR_OFFSET:  prdata <= 32'h0000_0000;
					IRQ_ENABLE_OFFSET: prdata[EV_W-1:0] <= irq_enable_r;
					default:           pslverr <= 1'b1;
				endcase
			end
		end
	end

endmodule : magnet_response_controller

// ===== reed_switch_model.sv
// Purpose: Reed switch closed by an external magnet
// Assumes: Bench moves the magnet on clock edges
// Notes:   Open contact is pulled low, so no magnet reads 0
`timescale 1ns/100ps
module reed_switch_model (
	input  wire logic ref_clk,
	input  wire logic magnet_near,
	output logic      reed_in
);
	initial reed_in = 1'b0;
	// One cycle of contact travel; gaps between holds come from the bench
	always @(posedge ref_clk) begin
		reed_in <= magnet_near;
	end
endmodule : reed_switch_model

// ===== magnet_response_controller_assertions.sv
// Purpose: Port-level checks of the magnet response controller
// Assumes: clk_en high, apart from short frozen spans with the reed idle
// Notes:   Hold time measured on the raw reed level, so bounds are lower ones
`timescale 1ns/100ps
module magnet_checker
	import magnet_pkg::*;
#(
	parameter int unsigned TICK_DIV = TICK_CYCLES
)(
	input wire logic             ref_clk,
	input wire logic             reset_n,
	input wire logic             reed_in,
	input wire logic             detection_met_in,
	input wire logic             charging_in,
	input wire logic             charge_done_in,
	input wire logic             burst_pacing_therapy_in,
	input wire logic             induction_in,
	input wire logic             tone_steady,
	input wire logic             tone_beat,
	input wire therapy_ctrl_type therapy_ctrl,
	input wire logic             withheld_log
);
	localparam int unsigned ONE_S = TICK_DIV * 99;
	localparam int unsigned TWO_S = TICK_DIV * 200;
	logic [31:0] held_r;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			held_r <= '0;
		end else if (!reed_in) begin
			held_r <= '0;
		end else if (held_r != '1) begin
			held_r <= held_r + 32'h0000_0001;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	a_gone_no_inhibit: assert property (!reed_in [*6] |-> !therapy_ctrl.inhibit)
		else $error("inhibit without magnet");
	a_actions_need_inhibit: assert property ((therapy_ctrl.charge_abort
		|| therapy_ctrl.shock_divert || therapy_ctrl.train_stop) |-> therapy_ctrl.inhibit)
		else $error("action without inhibit");
	a_abort_on_charge: assert property (therapy_ctrl.charge_abort |-> $past(charging_in))
		else $error("abort without charging");
	a_abort_delay: assert property (therapy_ctrl.charge_abort |-> held_r >= ONE_S)
		else $error("abort too early");
	a_divert_on_done: assert property (therapy_ctrl.shock_divert |-> $past(charge_done_in))
		else $error("divert without charge");
	a_divert_delay: assert property (therapy_ctrl.shock_divert |-> held_r >= TWO_S)
		else $error("divert too early");
	a_train_stop_delay: assert property ((therapy_ctrl.train_stop
		&& $past(burst_pacing_therapy_in || induction_in)) |-> held_r >= ONE_S)
		else $error("train stopped too early");
	a_tones_exclusive: assert property (!(tone_steady && tone_beat))
		else $error("both tones at once");
	a_withheld_pulse: assert property (withheld_log
		|-> $past(detection_met_in) ##1 !withheld_log)
		else $error("bad withheld pulse");
	c_withheld: cover property (withheld_log);
	c_divert: cover property (therapy_ctrl.shock_divert);
	c_beat: cover property (tone_beat);
endmodule : magnet_checker

bind magnet_response_controller magnet_checker #(.TICK_DIV(TICK_DIV)) i_chk (
	.ref_clk(ref_clk), .reset_n(reset_n), .reed_in(reed_in),
	.detection_met_in(detection_met_in), .charging_in(charging_in),
	.charge_done_in(charge_done_in), .burst_pacing_therapy_in(burst_pacing_therapy_in),
	.induction_in(induction_in), .tone_steady(tone_steady), .tone_beat(tone_beat),
	.therapy_ctrl(therapy_ctrl), .withheld_log(withheld_log)
);

// ===== magnet_response_controller_tb.sv
// Purpose: Self-checking bench for the magnet response controller
// Assumes: Tick divider of 4, so 1 s is 400 cycles
// Notes:   Mode-change holds dominate the run time
`timescale 1ns/100ps
module magnet_response_controller_tb;
	import magnet_pkg::*;
	localparam int unsigned SEC = 400;
	logic             ref_clk = 1'b0;
	logic             reset_n = 1'b0;
	logic             psel = 1'b0;
	logic             penable = 1'b0;
	logic             pwrite = 1'b0;
	logic [11:0]      paddr = '0;
	logic [31:0]      pwdata = '0;
	logic [31:0]      prdata, q;
	logic             near = 1'b0, vs = 1'b0, det = 1'b0, chg = 1'b0, dn = 1'b0, tr = 1'b0;
	logic             pready, pslverr, e, reed_in, irq, wl, ts, tb, seen, sw;
	logic             en = 1'b1;
	tachy_mode_type   em;
	therapy_ctrl_type tc;
	tachy_mode_type   mf [4] = '{MODE_MON_THERAPY, MODE_OFF, MODE_MONITOR_ONLY, MODE_STORAGE};
	tachy_mode_type   mt [4] = '{MODE_OFF, MODE_MON_THERAPY, MODE_MON_THERAPY, MODE_STORAGE};
	int               num_errors = 0;
	int               tests_run = 0;
	initial forever #2.5 ref_clk = ~ref_clk;
	reed_switch_model i_reed (.ref_clk(ref_clk), .magnet_near(near), .reed_in(reed_in));
	magnet_response_controller #(.TICK_DIV(4)) i_dut (
		.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(en), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .reed_in(reed_in), .vsense_in(vs), .detection_met_in(det),
		.charging_in(chg), .charge_done_in(dn), .burst_pacing_therapy_in(tr),
		.induction_in(tr), .effective_mode(em), .tone_steady(ts), .tone_beat(tb),
		.therapy_ctrl(tc), .withheld_log(wl), .irq(irq));
	////////////////////////////////////////////////////////////////////////////////
	task cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : cyc
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		// Only the watchdog ends a wait that never sees pready
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(q, exp);
	endtask : rd
	task give_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : give_verdict
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		cyc(20);
		reset_n <= 1'b1;
		cyc(2);
		rd(CTRL_OFFSET, 32'h0000_0000);
		rd(MODE_OFFSET, 32'h0000_0000);
		apb(1'b0, 12'h0FC, 32'h0000_0000);
		chk(32'(e), 32'h0000_0001);
		chk(q, 32'h0000_0000);
		apb(1'b1, MODE_OFFSET, 32'h0000_0003);
		rd(MODE_OFFSET, 32'h0000_0003);
		// A write while the enable is low must not land
		en <= 1'b0;
		apb(1'b1, MODE_OFFSET, 32'h0000_0001);
		en <= 1'b1;
		rd(MODE_OFFSET, 32'h0000_0003);
		rd(IRQ_CLEAR_OFFSET, 32'h0000_0000);
		$display("test registers done");
		near <= 1'b1;
		cyc(SEC);
		chk(32'({tc, ts, em}), 32'h0000_0003);
		near <= 1'b0;
		cyc(10);
		apb(1'b1, IRQ_ENABLE_OFFSET, 32'h0000_0001);
		apb(1'b1, CTRL_OFFSET, 32'h0000_0001);
		near <= 1'b1;
		cyc(10);
		chk(32'({tc.inhibit, em, irq}), 32'h0000_000D);
		vs <= 1'b1;
		det <= 1'b1;
		cyc(1);
		vs <= 1'b0;
		det <= 1'b0;
		seen = 1'b0;
		sw = 1'b0;
		repeat (8) begin
			@(posedge ref_clk);
			seen |= tb;
			sw |= wl;
		end
		chk(32'({seen, sw, ts}), 32'h0000_0006);
		chg <= 1'b1;
		tr <= 1'b1;
		cyc(SEC + 20);
		chk(32'(tc), 32'h0000_001D);
		chg <= 1'b0;
		dn <= 1'b1;
		cyc(SEC + 20);
		chk(32'(tc), 32'h0000_0017);
		apb(1'b1, IRQ_ENABLE_OFFSET, 32'h0000_0000);
		cyc(2);
		chk(32'(irq), 32'h0000_0000);
		apb(1'b1, IRQ_CLEAR_OFFSET, 32'h0000_001F);
		rd(IRQ_STATUS_OFFSET, 32'h0000_0000);
		near <= 1'b0;
		dn <= 1'b0;
		tr <= 1'b0;
		cyc(SEC);
		chk(32'(em), 32'(MODE_MONITOR_ONLY));
		cyc(SEC + 20);
		chk(32'(em), 32'(MODE_MON_THERAPY));
		rd(IRQ_STATUS_OFFSET, 32'h0000_0002);
		$display("test inhibit done");
		apb(1'b1, CTRL_OFFSET, 32'h0000_0003);
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, MODE_OFFSET, 32'(mf[i]));
			near <= 1'b1;
			cyc(30 * SEC - 100);
			rd(MODE_OFFSET, 32'(mf[i]));
			cyc(120);
			rd(MODE_OFFSET, 32'(mt[i]));
			chk(32'(ts), 32'(mt[i] != MODE_MON_THERAPY));
			near <= 1'b0;
			cyc(2 * SEC + 40);
		end
		rd(IRQ_STATUS_OFFSET, 32'h0000_0007);
		$display("test mode change done");
		give_verdict();
	end
	initial begin
		cyc(80000);
		num_errors++;
		$display("ERROR t=%0t watchdog expired", $time);
		give_verdict();
	end
endmodule : magnet_response_controller_tb
